//--- hw/ubs_cfg.svh
`ifndef UBS_CFG_SVH
`define UBS_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define UBS_OFF_DATA 3'h0
`define UBS_OFF_STATUS 3'h1
`define UBS_OFF_IRQ 3'h3
`define UBS_OFF_ENABLE 3'h4
`define UBS_OFF_FORMAT 3'h5

// ----------------------------------------
// field positions
// ----------------------------------------
`define UBS_ST_RXC 7
`define UBS_ST_TXC 6
`define UBS_ST_DRE 5
`define UBS_ST_STOP_BIT_ERROR_FLAG 4
`define UBS_ST_OVF 3
`define UBS_ST_PARITY_FAIL_FLAG 2
`define UBS_ST_RX9 0
`define UBS_EN_RX 4
`define UBS_EN_TX 3
`define UBS_EN_DS 2
`define UBS_EN_MP 1
`define UBS_EN_TX9 0
`define UBS_IRQ_RX_HI 5
`define UBS_IRQ_RX_LO 4
`define UBS_IRQ_TX_HI 3
`define UBS_IRQ_TX_LO 2
`define UBS_IRQ_DRE_HI 1
`define UBS_IRQ_DRE_LO 0
`define UBS_FMT_MODE_HI 7
`define UBS_FMT_MODE_LO 6
`define UBS_FMT_PAR_HI 5
`define UBS_FMT_PAR_LO 4
`define UBS_FMT_STOP2 3
`define UBS_FMT_SIZE_HI 2
`define UBS_FMT_SIZE_LO 0
`define UBS_FE_STOP_BIT_ERROR_FLAG 9
`define UBS_FE_PARITY_FAIL_FLAG 10

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define UBS_MODE_SPI 2'h3
`define UBS_SIZE_NINE 3'h7
`define UBS_SIZE_BASE 4'h5
`define UBS_NINE 4'h9
`define UBS_IRQ_RST 6'h00
`define UBS_ENABLE_RST 5'h00
`define UBS_FORMAT_RST 8'h03
`define UBS_OS_NORM 4'hf
`define UBS_OS_FAST 4'h7
`define UBS_HALF_NORM 4'h7
`define UBS_HALF_FAST 4'h3
`define UBS_FIFO_DEPTH 2'h2

`endif

//--- hw/ubs_pkg.sv
package ubs_pkg;

  typedef enum logic [0:0] {UBS_TX_IDLE = 1'b0, UBS_TX_SEND = 1'b1} ubs_tx_e;
  typedef enum logic [1:0] {
    UBS_RX_IDLE = 2'b00,
    UBS_RX_START = 2'b01,
    UBS_RX_DATA = 2'b11
  } ubs_rx_e;

  typedef struct packed {
    logic [15:0] div;
    ubs_tx_e tx_st;
    logic [3:0] tx_tick;
    logic [3:0] tx_bit;
    logic [12:0] tx_sh;
    logic [8:0] txbuf;
    logic txbuf_full;
    logic tx_act;
    logic txc;
    ubs_rx_e rx_st;
    logic [3:0] rx_tick;
    logic [3:0] rx_bit;
    logic [10:0] rx_sh;
    logic [10:0] hold;
    logic hold_v;
    logic [1:0][10:0] fifo;
    logic [1:0] cnt;
    logic ovf;
    logic [5:0] irq;
    logic [4:0] enable;
    logic [7:0] format;
    logic [7:0] rdata;
  } ubs_state_s;

endpackage : ubs_pkg

//--- hw/ubs_core.sv
// Behaviour
// - data writes fill transmit buffer; data reads return oldest receive entry
// - narrow characters: unused upper bits ignored on send, zero on receive
// - data write while buffer-empty flag clear is discarded
// - enabled transmitter moves buffered byte into idle shifter and sends it
// - receive buffer is two-entry fifo; each data read advances it
// - receive-complete high while fifo holds data; write one clears it unless a character waits in the holding stage
// - transmit-complete sets after frame ends with empty buffer; ack or one clears
// - buffer-empty flag high when buffer empty and after reset; write clears
// - three two-bit level fields request interrupts while their flags set
// - frame error mirrors first stop bit of next readable character only
// - overflow sets on full fifo, waiting character and new start bit
// - parity error set on failed check; reads zero with parity off
// - master spi mode: error flags, ninth bits, speed and filter unused
// - ninth received bit shown in status; read before data
// - ninth transmit bit taken from control; set before writing data
// - receiver enable claims pin; disabling flushes fifo and error flags
// - transmitter enable claims pin; disable waits for buffer and shifter empty
// - double speed makes divisor 8 instead of 16 in asynchronous modes
// - address filter mode drops every frame not marked as address
// - marker is ninth bit, or first stop bit for shorter characters
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "ubs_cfg.svh"

module ubs_core #(
  parameter int SAMPLE_DIV = 22
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic txd,
  output logic txd_oe_n,
  input wire logic rxd,
  output logic rxd_claimed,
  input wire logic txc_vector_done,
  output logic [1:0] irq_rx_level,
  output logic [1:0] irq_tx_level,
  output logic [1:0] irq_dre_level
);

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (SAMPLE_DIV < 1 || SAMPLE_DIV > 65536) begin : g_bad_div
    $error("SAMPLE_DIV out of range");
  end

  localparam logic [15:0] DIV_LAST = 16'(SAMPLE_DIV - 1);

  ubs_pkg::ubs_state_s s;
  ubs_pkg::ubs_state_s next_s;
  logic tick;
  logic spi;
  logic ds;
  logic par_on;
  logic [3:0] nb;
  logic [3:0] os_last;
  logic [3:0] half;
  logic [3:0] need;
  logic [8:0] mask;
  logic dre;
  logic [10:0] rx_cap;
  logic [8:0] rx_data;
  logic rx_stop;
  logic rx_parity_fail_flag;
  logic rx_mark;
  logic [12:0] frame;
  logic [3:0] flen;

  // ----------------------------------------
  // decoded settings
  // ----------------------------------------
  assign spi = s.format[`UBS_FMT_MODE_HI:`UBS_FMT_MODE_LO] == `UBS_MODE_SPI;
  // double speed
  // asynchronous and infrared modes only; synchronous and spi ignore it
  assign ds = s.enable[`UBS_EN_DS] && !s.format[`UBS_FMT_MODE_LO];
  assign par_on = s.format[`UBS_FMT_PAR_HI] && !spi;
  assign nb = (s.format[`UBS_FMT_SIZE_HI:`UBS_FMT_SIZE_LO] == `UBS_SIZE_NINE) ? `UBS_NINE :
      (4'(s.format[`UBS_FMT_SIZE_HI:`UBS_FMT_SIZE_LO]) + `UBS_SIZE_BASE);
  assign mask = ~(9'h1ff << nb);
  assign os_last = ds ? `UBS_OS_FAST : `UBS_OS_NORM;
  assign half = ds ? `UBS_HALF_FAST : `UBS_HALF_NORM;
  // data bits, parity, first stop bit; later stop bits are never sampled
  assign need = nb + 4'(par_on);
  assign tick = s.div == DIV_LAST;
  assign dre = !s.txbuf_full;

  // ----------------------------------------
  // frame assembly and check
  // ----------------------------------------
  always_comb begin
    frame = '1;
    frame[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < nb) begin
        frame[i + 1] = s.txbuf[i];
      end
    end
    if (par_on) begin
      frame[nb + 4'h1] = ^(s.txbuf & mask) ^ s.format[`UBS_FMT_PAR_LO];
    end
    flen = nb + 4'(par_on) + 4'(s.format[`UBS_FMT_STOP2]) + 4'h1;
  end

  // stop bit is sampled in the finishing cycle, so take it from the pin, not from next_s
  always_comb begin
    rx_cap = s.rx_sh;
    rx_cap[s.rx_bit] = rxd;
  end

  assign rx_data = rx_cap[8:0] & mask;
  assign rx_stop = rx_cap[nb + 4'(par_on)];
  assign rx_parity_fail_flag = par_on && (^rx_data ^ rx_cap[nb] ^ s.format[`UBS_FMT_PAR_LO]);
  assign rx_mark = (nb == `UBS_NINE) ? rx_data[8] : rx_stop;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.rdata = 8'h00;
    next_s.div = tick ? 16'h0000 : s.div + 16'h0001;
    // register reads
    if (rd) begin
      unique case (addr)
        `UBS_OFF_DATA: begin
          next_s.rdata = (s.cnt != 2'h0) ? s.fifo[0][7:0] : 8'h00;
          if (s.cnt != 2'h0) begin
            next_s.fifo[0] = s.fifo[1];
            next_s.cnt = s.cnt - 2'h1;
            next_s.ovf = 1'b0;
          end
        end
        `UBS_OFF_STATUS: begin
          next_s.rdata[`UBS_ST_RXC] = s.cnt != 2'h0;
          next_s.rdata[`UBS_ST_TXC] = s.txc;
          next_s.rdata[`UBS_ST_DRE] = dre;
          if (!spi && s.cnt != 2'h0) begin
            next_s.rdata[`UBS_ST_STOP_BIT_ERROR_FLAG] = s.fifo[0][`UBS_FE_STOP_BIT_ERROR_FLAG];
            next_s.rdata[`UBS_ST_PARITY_FAIL_FLAG] = s.fifo[0][`UBS_FE_PARITY_FAIL_FLAG] && par_on;
            next_s.rdata[`UBS_ST_RX9] = s.fifo[0][8];
          end
          next_s.rdata[`UBS_ST_OVF] = s.ovf && !spi;
        end
        `UBS_OFF_IRQ: next_s.rdata = {2'h0, s.irq};
        `UBS_OFF_ENABLE: next_s.rdata = {3'h0, s.enable};
        `UBS_OFF_FORMAT: next_s.rdata = s.format;
        default: next_s.rdata = 8'h00;
      endcase
    end
    // register writes
    if (wr) begin
      unique case (addr)
        `UBS_OFF_DATA: begin
          if (dre) begin
            next_s.txbuf = {s.enable[`UBS_EN_TX9] && !spi, wdata};
            next_s.txbuf_full = 1'b1;
          end
        end
        `UBS_OFF_STATUS: begin
          if (wdata[`UBS_ST_RXC]) begin
            next_s.cnt = 2'h0;
            next_s.hold_v = 1'b0;
          end
          if (wdata[`UBS_ST_TXC]) begin
            next_s.txc = 1'b0;
          end
        end
        `UBS_OFF_IRQ: next_s.irq = wdata[5:0];
        `UBS_OFF_ENABLE: next_s.enable = wdata[4:0];
        `UBS_OFF_FORMAT: next_s.format = wdata;
        default: ;
      endcase
    end
    if (txc_vector_done) begin
      next_s.txc = 1'b0;
    end
    next_s.tx_act = s.enable[`UBS_EN_TX] ||
        (s.tx_act && (s.tx_st != ubs_pkg::UBS_TX_IDLE || s.txbuf_full));
    // transmitter
    unique case (s.tx_st)
      ubs_pkg::UBS_TX_IDLE: begin
        if (s.tx_act && s.txbuf_full) begin
          next_s.tx_sh = frame;
          // one shift per frame bit, last stop bit included
          next_s.tx_bit = flen;
          next_s.tx_tick = 4'h0;
          next_s.txbuf_full = 1'b0;
          next_s.tx_st = ubs_pkg::UBS_TX_SEND;
        end
      end
      ubs_pkg::UBS_TX_SEND: begin
        if (tick) begin
          if (s.tx_tick == os_last) begin
            next_s.tx_tick = 4'h0;
            next_s.tx_sh = {1'b1, s.tx_sh[12:1]};
            next_s.tx_bit = s.tx_bit - 4'h1;
            if (s.tx_bit == 4'h0) begin
              next_s.tx_st = ubs_pkg::UBS_TX_IDLE;
              if (!next_s.txbuf_full) begin
                next_s.txc = 1'b1;
              end
            end
          end else begin
            next_s.tx_tick = s.tx_tick + 4'h1;
          end
        end
      end
    endcase
    // holding stage into fifo; a pop in the same cycle frees its slot
    if (s.hold_v && next_s.cnt < `UBS_FIFO_DEPTH) begin
      next_s.fifo[next_s.cnt[0]] = s.hold;
      next_s.cnt = next_s.cnt + 2'h1;
      next_s.hold_v = 1'b0;
    end
    // receiver
    unique case (s.rx_st)
      ubs_pkg::UBS_RX_IDLE: begin
        if (tick && !rxd) begin
          next_s.rx_st = ubs_pkg::UBS_RX_START;
          next_s.rx_tick = 4'h0;
          if (s.cnt == `UBS_FIFO_DEPTH && s.hold_v) begin
            next_s.ovf = 1'b1;
          end
        end
      end
      ubs_pkg::UBS_RX_START: begin
        if (tick) begin
          if (s.rx_tick == half) begin
            next_s.rx_st = rxd ? ubs_pkg::UBS_RX_IDLE : ubs_pkg::UBS_RX_DATA;
            next_s.rx_tick = 4'h0;
            next_s.rx_bit = 4'h0;
          end else begin
            next_s.rx_tick = s.rx_tick + 4'h1;
          end
        end
      end
      ubs_pkg::UBS_RX_DATA: begin
        if (tick) begin
          if (s.rx_tick == os_last) begin
            next_s.rx_tick = 4'h0;
            next_s.rx_sh[s.rx_bit] = rxd;
            next_s.rx_bit = s.rx_bit + 4'h1;
            if (s.rx_bit == need) begin
              next_s.rx_st = ubs_pkg::UBS_RX_IDLE;
              // drop data frames
              // a frame finishing while the stage is still full is lost
              if (!(s.enable[`UBS_EN_MP] && !spi && !rx_mark) && !next_s.hold_v) begin
                next_s.hold = {rx_parity_fail_flag, !rx_stop, rx_data};
                next_s.hold_v = 1'b1;
              end
            end
          end else begin
            next_s.rx_tick = s.rx_tick + 4'h1;
          end
        end
      end
      default: next_s.rx_st = ubs_pkg::UBS_RX_IDLE;
    endcase
    if (!s.enable[`UBS_EN_RX]) begin
      next_s.rx_st = ubs_pkg::UBS_RX_IDLE;
      next_s.cnt = 2'h0;
      next_s.hold_v = 1'b0;
      next_s.ovf = 1'b0;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.tx_sh <= '1;
      s.irq <= `UBS_IRQ_RST;
      s.enable <= `UBS_ENABLE_RST;
      s.format <= `UBS_FORMAT_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata = s.rdata;
  assign txd = s.tx_sh[0];
  assign txd_oe_n = !s.tx_act;
  assign rxd_claimed = s.enable[`UBS_EN_RX];
  assign irq_rx_level = (s.cnt != 2'h0) ? s.irq[`UBS_IRQ_RX_HI:`UBS_IRQ_RX_LO] : 2'h0;
  assign irq_tx_level = s.txc ? s.irq[`UBS_IRQ_TX_HI:`UBS_IRQ_TX_LO] : 2'h0;
  assign irq_dre_level = dre ? s.irq[`UBS_IRQ_DRE_HI:`UBS_IRQ_DRE_LO] : 2'h0;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_dre_after_reset: assert property (@(posedge clk) $fell(rst) |-> dre)
    else $error("buffer-empty flag low after reset");
  a_dre_write_clear: assert property (@(posedge clk) disable iff (rst)
    wr && addr == `UBS_OFF_DATA && dre |=> !dre || s.tx_st == ubs_pkg::UBS_TX_SEND)
    else $error("data write did not fill buffer");
  a_write_discard: assert property (@(posedge clk) disable iff (rst)
    wr && addr == `UBS_OFF_DATA && !dre |=> s.txbuf == $past(s.txbuf))
    else $error("write with full buffer changed it");
  a_tx_load_idle: assert property (@(posedge clk) disable iff (rst)
    s.tx_act && s.txbuf_full && s.tx_st == ubs_pkg::UBS_TX_IDLE
      |=> s.tx_st == ubs_pkg::UBS_TX_SEND && !txd)
    else $error("buffered byte not loaded");
  a_read_oldest: assert property (@(posedge clk) disable iff (rst)
    rd && addr == `UBS_OFF_DATA && s.cnt != 2'h0 |=> rdata == $past(s.fifo[0][7:0]))
    else $error("data read returned wrong entry");
  a_narrow_zero: assert property (@(posedge clk) disable iff (rst)
    rd && addr == `UBS_OFF_DATA && nb < 4'h8 ##1 $stable(s.format)
      |-> (rdata & ~mask[7:0]) == 8'h00)
    else $error("upper bits not zero");
  a_rx_flush_off: assert property (@(posedge clk) disable iff (rst)
    !s.enable[`UBS_EN_RX] |=> s.cnt == 2'h0 && !s.ovf && irq_rx_level == 2'h0)
    else $error("fifo not flushed on disable");
  a_ovf_set: assert property (@(posedge clk) disable iff (rst)
    s.enable[`UBS_EN_RX] && s.rx_st == ubs_pkg::UBS_RX_IDLE && tick && !rxd
      && s.cnt == `UBS_FIFO_DEPTH && s.hold_v && !(rd && addr == `UBS_OFF_DATA) |=> s.ovf)
    else $error("overflow not flagged");
  a_parity_fail_flag_off: assert property (@(posedge clk) disable iff (rst)
    rd && addr == `UBS_OFF_STATUS && !par_on |=> !rdata[`UBS_ST_PARITY_FAIL_FLAG])
    else $error("parity flag set with parity off");
  a_txc_end: assert property (@(posedge clk) disable iff (rst)
    s.tx_st == ubs_pkg::UBS_TX_SEND && tick && s.tx_tick == os_last && s.tx_bit == 4'h0
      && !s.txbuf_full && !(wr && addr == `UBS_OFF_DATA) |=> s.txc)
    else $error("transmit-complete not set");
  a_tx_hold_pin: assert property (@(posedge clk) disable iff (rst)
    s.tx_act && (s.txbuf_full || s.tx_st == ubs_pkg::UBS_TX_SEND) |=> !txd_oe_n)
    else $error("pin released before drain");
  a_rxc_level: assert property (@(posedge clk) disable iff (rst)
    rd && addr == `UBS_OFF_STATUS |=> rdata[`UBS_ST_RXC] == ($past(s.cnt) != 2'h0))
    else $error("receive-complete flag wrong");

endmodule : ubs_core

`default_nettype wire

//--- bench/ubs_remote.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// remote serial partner
// ----------------------------------------
module ubs_remote (
  input wire logic clk,
  input wire logic txd,
  input wire logic txd_oe_n,
  output logic rxd
);
  int bit_clk = 16;
  int nbits = 8;
  logic [8:0] got[$];

  // mark level between frames, as a real line idles
  initial rxd = 1'b1;

  task automatic send(input logic [11:0] bits, input int n);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (bit_clk) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (bit_clk) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask : send

  // mid-bit sampling; only a driven pin can start a frame
  always begin : sample_frame
    logic [8:0] v;
    v = 9'h000;
    @(posedge clk iff (txd_oe_n === 1'b0 && txd === 1'b0));
    repeat (bit_clk / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_clk) @(posedge clk);
      v[i] = txd;
    end
    repeat (bit_clk) @(posedge clk);
    got.push_back(v);
  end
endmodule : ubs_remote

`default_nettype wire

//--- bench/test_uart_buffer_status_control.sv
`timescale 1ns/100ps
`default_nettype none

module test_uart_buffer_status_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic txc_vector_done = 1'b0;
  logic [7:0] rdata;
  logic txd;
  logic txd_oe_n;
  logic rxd;
  logic rxd_claimed;
  logic [1:0] irq_rx_level;
  logic [1:0] irq_tx_level;
  logic [1:0] irq_dre_level;
  int failures = 0;
  int tests_run = 0;

  // short sample tick keeps frames at 16 clocks a bit
  ubs_core #(.SAMPLE_DIV(1)) dut (
    .clk(clk),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .txd(txd),
    .txd_oe_n(txd_oe_n),
    .rxd(rxd),
    .rxd_claimed(rxd_claimed),
    .txc_vector_done(txc_vector_done),
    .irq_rx_level(irq_rx_level),
    .irq_tx_level(irq_tx_level),
    .irq_dre_level(irq_dre_level)
  );

  ubs_remote rem (
    .clk(clk),
    .txd(txd),
    .txd_oe_n(txd_oe_n),
    .rxd(rxd)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // access and checking tasks
  // ----------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check({1'b0, rdata}, {1'b0, e});
  endtask : rchk

  // bounded wait for captured transmit frames
  task automatic frames(input int n);
    for (int i = 0; i < 4000 && rem.got.size() < n; i++) @(posedge clk);
  endtask : frames

  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // watchdog well beyond the expected few thousand cycles
  initial begin
    #1000000;
    failures++;
    report_and_stop();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk(3'h1, 8'h20); // empty after reset
    rchk(3'h5, 8'h03);
    rchk(3'h2, 8'h00);
    check(9'(irq_dre_level), 9'h0); // level zero silent
    check(9'(txd_oe_n), 9'h1); // pin released
    wreg(3'h3, 8'h39); // reserved bits zero
    #1 check(9'(irq_dre_level), 9'h1); // level shown
    note("reset");
    wreg(3'h0, 8'ha5);
    rchk(3'h1, 8'h00); // write clears flag
    wreg(3'h0, 8'h11);
    wreg(3'h4, 8'h08);
    repeat (4) @(posedge clk);
    #1 check(9'(txd_oe_n), 9'h0); // pin claimed
    rchk(3'h1, 8'h20); // buffer moved on enable
    wreg(3'h0, 8'h3c);
    wreg(3'h0, 8'h77);
    rchk(3'h1, 8'h00); // buffer still full
    frames(2);
    repeat (400) @(posedge clk);
    check(9'(rem.got.size()), 9'h2); // extra writes lost
    check(rem.got.pop_front(), 9'h0a5); // sent
    check(rem.got.pop_front(), 9'h03c); // second byte
    rchk(3'h1, 8'h60); // complete after last frame
    check(9'(irq_tx_level), 9'h2); // tx level
    wreg(3'h1, 8'h40); // error positions zero
    rchk(3'h1, 8'h20); // write one clears
    note("transmit");
    wreg(3'h5, 8'h07);
    wreg(3'h4, 8'h09); // ninth bit before data
    rem.nbits = 9;
    wreg(3'h0, 8'h5a);
    wreg(3'h4, 8'h00);
    repeat (20) @(posedge clk);
    #1 check(9'(txd_oe_n), 9'h0); // disable deferred
    frames(1);
    check(rem.got.pop_front(), 9'h15a); // ninth bit sent
    repeat (40) @(posedge clk);
    #1 check(9'(txd_oe_n), 9'h1); // released after frame
    rchk(3'h1, 8'h60); // set after frame
    @(posedge clk);
    txc_vector_done <= 1'b1;
    @(posedge clk);
    txc_vector_done <= 1'b0;
    rchk(3'h1, 8'h20); // vector clears flag
    note("ninth bit");
    wreg(3'h5, 8'h03);
    wreg(3'h4, 8'h10);
    #1 check(9'(rxd_claimed), 9'h1); // pin claimed
    rem.send({3'h0, 1'b1, 8'h81}, 9);
    rem.send({3'h0, 1'b0, 8'h42}, 9);
    repeat (4) @(posedge clk);
    check(9'(irq_rx_level), 9'h3); // rx level
    rchk(3'h1, 8'ha0); // good stop
    rchk(3'h0, 8'h81); // oldest first
    rchk(3'h1, 8'hb0); // bad stop
    rchk(3'h0, 8'h42); // second entry
    rchk(3'h1, 8'h20); // empty clears
    for (int i = 1; i < 5; i++) rem.send({4'h1, 8'(i)}, 9);
    repeat (4) @(posedge clk);
    rchk(3'h1, 8'ha8); // overflow seen
    rchk(3'h0, 8'h01); // oldest kept
    rchk(3'h1, 8'ha0); // cleared by read
    wreg(3'h4, 8'h00);
    rchk(3'h1, 8'h20); // disable flushes
    #1 check(9'(rxd_claimed), 9'h0); // pin released
    note("receive");
    wreg(3'h5, 8'h02);
    wreg(3'h4, 8'h10);
    rem.send({4'h0, 8'hff}, 8);
    repeat (4) @(posedge clk);
    rchk(3'h0, 8'h7f); // upper bits zero
    wreg(3'h5, 8'h23);
    rem.send({2'h3, 8'h03}, 10);
    repeat (4) @(posedge clk);
    rchk(3'h1, 8'ha4); // parity fail
    wreg(3'h1, 8'h80); // error positions zero
    rchk(3'h1, 8'h20); // write one flushes
    note("narrow and parity");
    wreg(3'h5, 8'h07);
    wreg(3'h4, 8'h12);
    rem.send({2'h2, 8'h11}, 10);
    rem.send({2'h3, 8'ha5}, 10);
    repeat (4) @(posedge clk);
    rchk(3'h1, 8'ha1); // data frame dropped
    rchk(3'h0, 8'ha5); // address frame kept
    wreg(3'h5, 8'hc3);
    wreg(3'h4, 8'h10);
    rem.send({3'h0, 1'b0, 8'h55}, 9);
    repeat (4) @(posedge clk);
    rchk(3'h1, 8'ha0); // error flag unused
    rchk(3'h0, 8'h55);
    note("filter and spi");
    wreg(3'h5, 8'h03);
    wreg(3'h4, 8'h0c);
    rem.bit_clk = 8;
    rem.nbits = 8;
    wreg(3'h0, 8'h96);
    frames(1);
    check(9'(rem.got.size()), 9'h1); // half bit time
    check(rem.got.pop_front(), 9'h096); // data intact
    note("double speed");
    report_and_stop();
  end
endmodule : test_uart_buffer_status_control

`default_nettype wire
